// ==== host_port_pkg.sv ====
package host_port_pkg;

  localparam int unsigned DATA_W       = 8;
  localparam int unsigned ADDR_W       = 8;

  // host-side timing, figures in ns
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned T_VD1_NS      = 140;
  localparam int unsigned T_VD2_NS      = 60;
  localparam int unsigned T_XFER_NONMUX_NS = 260;
  localparam int unsigned T_XFER_MUX_NS    = 300;

  // longest times round down, never below one cycle
  localparam int unsigned VD1_CYC_RAW = T_VD1_NS / CLK_PERIOD_NS;
  localparam int unsigned VD1_CYC     = (VD1_CYC_RAW < 1) ? 1 : VD1_CYC_RAW;
  localparam int unsigned VD2_CYC_RAW = T_VD2_NS / CLK_PERIOD_NS;
  localparam int unsigned VD2_CYC     = (VD2_CYC_RAW < 1) ? 1 : VD2_CYC_RAW;

  // reset values
  localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } access_state_t;

endpackage

// ==== host_bus_port.sv ====
`timescale 1ns/100ps
`default_nettype none

module host_bus_port
  import host_port_pkg::*;
#(
  parameter int unsigned DW = host_port_pkg::DATA_W,
  parameter int unsigned AW = host_port_pkg::ADDR_W
) (
  input  wire logic          clock_i,
  input  wire logic          arst_n_i,
  input  wire logic          bus_multiplex_select_i,
  input  wire logic          strobe_format_select_i,
  input  wire logic          reduced_pin_variant_i,
  input  wire logic          cs_n_i,
  input  wire logic          rd_n_i,
  input  wire logic          wr_n_i,
  input  wire logic          ale_i,
  input  wire logic          address_strobe_i,
  input  wire logic          data_strobe_n_i,
  input  wire logic          rw_dir_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] data_o,
  output logic               data_oe_o,
  output logic      [AW-1:0] reg_addr_o,
  output logic      [DW-1:0] reg_wdata_o,
  output logic               reg_we_o,
  output logic               reg_re_o,
  input  wire logic [DW-1:0] reg_rdata_i,
  output logic               mode_mux_o,
  output logic               mode_format_o,
  output logic               strap_conflict_o
);
  import host_port_pkg::*;

  logic          straps_taken_reg;
  logic          mux_reg;
  logic          fmt_reg;
  logic          conflict_reg;
  logic          strobe_low;
  logic          strobe_low_d_reg;
  logic          latch_d_reg;
  logic          latch_now;
  logic          is_read;
  logic          start_access;
  logic          end_access;
  logic [DW-1:0] data_d_reg;
  logic [AW-1:0] latched_addr_reg;
  access_state_t state_reg;
  access_state_t state_next;

  // straps are caught once, just after reset release, not under the reset
  // a strap moved later is ignored until the next reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      straps_taken_reg <= 1'b0;
      mux_reg          <= 1'b1;
      fmt_reg          <= 1'b0;
      conflict_reg     <= 1'b0;
    end else if (!straps_taken_reg) begin
      straps_taken_reg <= 1'b1;
      // reduced-pin part has no separate address pins, so force sharing
      mux_reg          <= bus_multiplex_select_i | reduced_pin_variant_i;
      fmt_reg          <= strobe_format_select_i;
      conflict_reg     <= reduced_pin_variant_i & ~bus_multiplex_select_i;
    end
  end

  assign mode_mux_o       = mux_reg;
  assign mode_format_o    = fmt_reg;
  assign strap_conflict_o = conflict_reg;

  // both strobes low is an illegal separate-strobe cycle and starts nothing
  always_comb begin
    if (fmt_reg) begin
      strobe_low = ~data_strobe_n_i;
      is_read    = rw_dir_i;
      latch_now  = address_strobe_i;
    end else begin
      strobe_low = rd_n_i ^ wr_n_i;
      is_read    = ~rd_n_i;
      latch_now  = ale_i;
    end
  end

  // chip select qualifies only the falling strobe edge
  // a fall under an idle chip select is dropped until the strobe rises again
  assign start_access = straps_taken_reg & strobe_low & ~strobe_low_d_reg
                        & ~cs_n_i;
  assign end_access   = ~strobe_low & strobe_low_d_reg;

  // state and event qualifier, shared by the register-side strobes
  function automatic logic state_event(input access_state_t cur,
                                       input access_state_t st,
                                       input logic          ev);
    return (cur == st) && ev;
  endfunction

  // one sample per edge; a strobe shorter than a clock period may be missed
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_low_d_reg <= 1'b0;
      latch_d_reg      <= 1'b0;
      data_d_reg       <= DATA_RST;
    end else begin
      strobe_low_d_reg <= strobe_low;
      latch_d_reg      <= latch_now;
      data_d_reg       <= data_i;
    end
  end

  // the value sampled while the latch was still high is the address
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      latched_addr_reg <= ADDR_RST;
    end else if (mux_reg && latch_d_reg && !latch_now) begin
      latched_addr_reg <= AW'(data_d_reg);
    end
  end

  // a new fall cannot arrive mid-access, a rise must come first
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_access) begin
          state_next = is_read ? ST_READ : ST_WRITE;
        end
      end
      ST_READ: begin
        if (end_access) begin
          state_next = ST_IDLE;
        end
      end
      ST_WRITE: begin
        if (end_access) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // address presented to the register file at strobe fall
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_addr_o <= ADDR_RST;
    end else if (state_event(state_reg, ST_IDLE, start_access)) begin
      reg_addr_o <= mux_reg ? latched_addr_reg : addr_i;
    end
  end

  // register read strobe one cycle after the fall; data follows a cycle later
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_re_o <= 1'b0;
    end else begin
      reg_re_o <= state_event(state_reg, ST_IDLE, start_access) && is_read;
    end
  end

  // drive within two cycles of the fall, well inside the valid-data limit
  // register file must answer combinationally while reg_re_o is high
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      data_o    <= DATA_RST;
      data_oe_o <= 1'b0;
    end else if (state_reg != ST_READ || end_access) begin
      data_oe_o <= 1'b0;
    end else if (reg_re_o) begin
      data_o    <= reg_rdata_i;
      data_oe_o <= 1'b1;
    end
  end

  // data sampled in the cycle before the rising strobe edge; hold under a cycle is enough
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      reg_wdata_o <= DATA_RST;
      reg_we_o    <= 1'b0;
    end else begin
      reg_we_o <= state_event(state_reg, ST_WRITE, end_access);
      if (state_event(state_reg, ST_WRITE, end_access)) begin
        reg_wdata_o <= data_d_reg;
      end
    end
  end

endmodule

`default_nettype wire

// ==== host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic       clock_i,
  input  wire logic       mux_i,
  input  wire logic       fmt_i,
  input  wire logic [7:0] bus_i,
  output logic            cs_n_o,
  output logic            rd_n_o,
  output logic            wr_n_o,
  output logic            ds_n_o,
  output logic            ale_o,
  output logic            as_o,
  output logic            dir_o,
  output logic      [7:0] addr_o,
  output logic      [7:0] d_o
);
  initial {cs_n_o, rd_n_o, wr_n_o, ds_n_o, ale_o, as_o, dir_o, addr_o, d_o} = 23'h780000;
  task automatic step(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic acc(input logic rd, cs, input logic [7:0] a, d, output logic [7:0] q);
    step(1);
    addr_o = mux_i ? ~a : a;
    d_o = a;
    ale_o = mux_i & ~fmt_i;
    as_o = mux_i & fmt_i;
    step(2);
    {ale_o, as_o} = 2'h0;
    // released bus shows the inverse, never a stale match
    d_o = rd ? ~a : d;
    cs_n_o = ~cs;
    dir_o = rd;
    step(2);
    if (fmt_i) ds_n_o = 1'b0;
    else if (rd) rd_n_o = 1'b0;
    else wr_n_o = 1'b0;
    step(8);
    q = bus_i;
    {rd_n_o, wr_n_o, ds_n_o} = 3'h7;
    step(2);
    cs_n_o = 1'b1;
    d_o = ~d_o;
    step(3);
  endtask
endmodule
`default_nettype wire

// ==== host_bus_port_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module host_bus_port_chk (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic bus_multiplex_select_i,
  input wire logic strobe_format_select_i,
  input wire logic reduced_pin_variant_i,
  input wire logic cs_n_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic data_strobe_n_i,
  input wire logic rw_dir_i,
  input wire logic data_oe_o,
  input wire logic reg_we_o,
  input wire logic reg_re_o,
  input wire logic mode_mux_o,
  input wire logic mode_format_o,
  input wire logic strap_conflict_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  property p_rd; $fell(rd_n_i) && !cs_n_i && !mode_format_o |=> reg_re_o ##1 data_oe_o; endproperty
  a_rd: assert property (p_rd) else $error("late read data");
  property p_ds; $fell(data_strobe_n_i) && !cs_n_i && rw_dir_i && mode_format_o
    |=> reg_re_o ##1 data_oe_o; endproperty
  a_ds: assert property (p_ds) else $error("late strobe read data");
  property p_rel; data_oe_o && rd_n_i && data_strobe_n_i |=> !data_oe_o; endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_we;
    reg_we_o |-> $past(wr_n_i && data_strobe_n_i) && !$past(wr_n_i && data_strobe_n_i, 2);
  endproperty
  a_we: assert property (p_we) else $error("write not at strobe end");
  property p_cs; $fell(rd_n_i) && cs_n_i |=> !reg_re_o ##1 !data_oe_o; endproperty
  a_cs: assert property (p_cs) else $error("unselected read taken");
  property p_cf;
    !$past(arst_n_i) || strap_conflict_o == (reduced_pin_variant_i & ~bus_multiplex_select_i);
  endproperty
  a_cf: assert property (p_cf) else $error("bad conflict flag");
  property p_mx;
    !$past(arst_n_i) || mode_mux_o == (bus_multiplex_select_i | reduced_pin_variant_i);
  endproperty
  a_mx: assert property (p_mx) else $error("bad multiplex mode");
  property p_fm; !$past(arst_n_i) || mode_format_o == strobe_format_select_i; endproperty
  a_fm: assert property (p_fm) else $error("bad strobe format");
  c_rd: cover property ($rose(data_oe_o));
  c_wr: cover property (reg_we_o && mode_mux_o);
  c_cf: cover property (strap_conflict_o);
endmodule
bind host_bus_port host_bus_port_chk u_chk (.*);
`default_nettype wire

// ==== byte_wide_host_bus_port_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module byte_wide_host_bus_port_tb;
  import host_port_pkg::*;
  logic clock_i = 1'b0, arst_n_i = 1'b0, mux = 1'b0, fmt = 1'b0, red = 1'b0;
  logic cs_n, rd_n, wr_n, ale, as_s, ds_n, dir, oe, we, re, mm, mf, sc;
  logic [7:0] addr, hd, bus, dq, ra, wd;
  logic [15:0] last_w = 16'h0;
  int n_fail = 0, checks = 0;
  always #12.5 clock_i = ~clock_i;
  assign bus = oe ? dq : hd;
  always @(posedge clock_i) if (we === 1'b1) last_w <= {ra, wd};
  host_model u_host (.clock_i(clock_i), .mux_i(mm), .fmt_i(mf), .bus_i(bus), .cs_n_o(cs_n),
    .rd_n_o(rd_n), .wr_n_o(wr_n), .ds_n_o(ds_n), .ale_o(ale), .as_o(as_s), .dir_o(dir),
    .addr_o(addr), .d_o(hd));
  host_bus_port u_dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .bus_multiplex_select_i(mux),
    .strobe_format_select_i(fmt), .reduced_pin_variant_i(red), .cs_n_i(cs_n), .rd_n_i(rd_n),
    .wr_n_i(wr_n), .ale_i(ale), .address_strobe_i(as_s), .data_strobe_n_i(ds_n),
    .rw_dir_i(dir), .addr_i(addr), .data_i(bus), .data_o(dq), .data_oe_o(oe),
    .reg_addr_o(ra), .reg_wdata_o(wd), .reg_we_o(we), .reg_re_o(re),
    .reg_rdata_i(ra ^ 8'hA5), .mode_mux_o(mm), .mode_format_o(mf), .strap_conflict_o(sc));
  task automatic cmp(input logic [15:0] exp, got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic rst(input logic m, f, r);
    @(posedge clock_i);
    #1;
    arst_n_i = 1'b0;
    {mux, fmt, red} = {m, f, r};
    repeat (8) @(posedge clock_i);
    cmp(16'h20, {mm, mf, sc, oe, we, re});
    #1;
    arst_n_i = 1'b1;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic rw(input logic [7:0] a, d);
    logic [7:0] q;
    u_host.acc(1'b0, 1'b1, a, d, q);
    cmp({a, d}, last_w);
    u_host.acc(1'b1, 1'b1, a, d, q);
    cmp(a ^ 8'hA5, q);
    cmp(1'b0, oe);
  endtask
  task automatic t_modes;
    for (int i = 0; i < 4; i++) begin
      rst(i[1], i[0], 1'b0);
      cmp(i[1:0], {mm, mf});
      rw(8'(8'hFF - i * 8'h55), 8'(i * 8'h55));
    end
  endtask
  task automatic t_reduced;
    rst(1'b0, 1'b0, 1'b1);
    cmp(3'h5, {mm, mf, sc});
    rw(8'h81, 8'h7E);
  endtask
  task automatic t_refuse;
    logic [7:0]  q;
    logic [15:0] prev;
    prev = last_w;
    u_host.acc(1'b0, 1'b0, 8'h3C, 8'hC3, q);
    cmp(prev, last_w);
    u_host.acc(1'b1, 1'b0, 8'hA5, 8'h00, q);
    cmp(8'h5A, q);
  endtask
  task automatic results;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    t_modes;
    t_reduced;
    t_refuse;
    results;
  end
  // whole run is a few hundred cycles; this bounds a hang
  initial begin
    #200000;
    n_fail++;
    results;
  end
endmodule
`default_nettype wire
